// file: fau_align.sv
// Alignment shifter: arithmetic right shift, one place per clock.
`timescale 1ns/10ps
`default_nettype none
module fau_align (
	input wire logic ref_clk,
	input wire logic sys_rst,
	fau_if.align aif
);
	import fau_pkg::*;
	fau_al_t st, nx;

	// A load takes the operand and count; each busy cycle shifts once.
	always_comb begin
		nx = st;
		if (aif.al_load) begin
			nx.val = aif.al_din;
			nx.cnt = aif.al_cnt;
			nx.busy = (aif.al_cnt != 6'h00);
		end else if (st.busy) begin
			nx.val = {st.val[47], st.val[47:1]}; // RQ5
			nx.cnt = st.cnt - 6'h01;
			nx.busy = (st.cnt != 6'h01);
		end
	end

	// State register.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign aif.al_busy = st.busy;
	assign aif.al_dout = st.val;
endmodule : fau_align
`default_nettype wire

// file: fau_defs.svh
// Constants of the floating arithmetic unit: field layout, limits, zero word, jump address.
// Contract
// RQ1: Word splits into 36-bit mantissa, 12-bit exponent.
// RQ2: Mantissa signed fraction, exponent signed power.
// RQ3: Negative fields use two's complement form.
// RQ4: Float prefix selects floating form of instruction.
// RQ5: Smaller exponent operand shifts right by difference.
// RQ6: Difference over 35 zeroes operand, no shifting.
// RQ7: Memory operand shifts only after its rewrite.
// RQ8: Equal exponents compute from unshifted slave copy.
// RQ9: Overlap rewrite when accumulator operand is smaller.
// RQ10: Result exponent is the larger operand exponent.
// RQ11: Memory operand exponent field stays unchanged.
// RQ12: Subtract adds complemented subtrahend mantissa.
// RQ13: Multiply adds exponents, multiplies mantissas.
// RQ14: Rounding adds low-half MSB, low register restored.
// RQ15: Unrounded product halves share one exponent.
// RQ16: Divide subtracts exponents, divides mantissas.
// RQ17: Double divide takes exponent from accumulator only.
// RQ18: Multiply and divide overlap the memory rewrite.
// RQ19: Accumulating multiplies restore multiplicand before arithmetic.
// RQ20: Mantissa sign at top, exponent low twelve.
// RQ21: Mantissa overflow shifts right, increments exponent.
// RQ22: Normalize left while top bits match; 36 gives zero.
// RQ23: Clear overflow indicator, never set in float.
// RQ24: Exponent fault jumps to zero, saves return.
`ifndef FAU_DEFS_SVH
`define FAU_DEFS_SVH
`define FAU_WORD_W 48
`define FAU_MANT_LSB 12
`define FAU_EXP_MSB 11
`define FAU_ALIGN_MAX 35
`define FAU_NORM_MAX 36
`define FAU_EXP_MAX 2047
`define FAU_EXP_MIN -2048
`define FAU_FZERO 48'h000000000000
`define FAU_MANT_MASK 48'hFFFFFFFFF000
`define FAU_JUMP_ADDR 15'h0000
`endif

// file: fau_if.sv
// Interface joining the sequencer to the alignment shifter and normalizer.
`timescale 1ns/10ps
`default_nettype none
interface fau_if;
	import fau_pkg::*;
	logic al_load;
	logic [5:0] al_cnt;
	fau_word_t al_din;
	fau_word_t al_dout;
	logic al_busy;
	fau_word_t nm_mant;
	fau_word_t nm_mant_o;
	fau_exp_t nm_exp;
	fau_exp_t nm_exp_o;
	logic nm_float;
	logic nm_zero;
	modport align (input al_load, al_cnt, al_din, output al_dout, al_busy);
	modport norm (input nm_mant, nm_exp, nm_float,
		output nm_mant_o, nm_exp_o, nm_zero);
endinterface : fau_if
`default_nettype wire

// file: fau_mem_model.sv
// Core memory stand-in: serves one operand read and acknowledges writes.
`timescale 1ns/10ps
`default_nettype none
module fau_mem_model (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic rd_go,
	input wire fau_pkg::fau_word_t rd_word,
	input wire logic slow,
	input wire logic mem_wr_req,
	input wire fau_pkg::fau_word_t mem_wr_data,
	output logic mem_valid,
	output fau_pkg::fau_word_t mem_data,
	output logic mem_wr_ack,
	output int wr_count,
	output fau_pkg::fau_word_t wr_first,
	output fau_pkg::fau_word_t wr_last,
	output int rw_gap
);
	import fau_pkg::*;
	int rd_wait;
	int ack_wait;
	logic gap_on;
	// Latencies stretch when slow is set, so both quick and lazy memory
	// timing reach the sequencer. The data lines toggle outside the valid
	// cycle, so a design that samples one cycle late never sees a stale match.
	always @(posedge ref_clk) begin
		mem_valid <= 1'b0;
		mem_wr_ack <= 1'b0;
		mem_data <= ~mem_data;
		if (sys_rst) begin
			rd_wait <= -1;
			ack_wait <= 0;
			wr_count <= 0;
			gap_on <= 1'b0;
			rw_gap <= 0;
			mem_data <= 48'h0;
		end else begin
			if (rd_go) begin
				rd_wait <= slow ? 4 : 1;
				wr_count <= 0;
				rw_gap <= 0;
			end else if (rd_wait == 0) begin
				mem_valid <= 1'b1;
				mem_data <= rd_word;
				rd_wait <= -1;
			end else if (rd_wait > 0) begin
				rd_wait <= rd_wait - 1;
			end
			// Cycles from the read edge to the first write request.
			if (mem_valid) begin
				gap_on <= 1'b1;
			end else if (gap_on) begin
				rw_gap <= rw_gap + 1;
				if (mem_wr_req) gap_on <= 1'b0;
			end
			if (mem_wr_req && !mem_wr_ack) begin
				if (ack_wait >= (slow ? 3 : 0)) begin
					mem_wr_ack <= 1'b1;
					ack_wait <= 0;
					wr_count <= wr_count + 1;
					wr_last <= mem_wr_data;
					if (wr_count == 0) wr_first <= mem_wr_data;
				end else begin
					ack_wait <= ack_wait + 1;
				end
			end
		end
	end
endmodule : fau_mem_model
`default_nettype wire

// file: fau_norm.sv
// Normalizer: left shifts while the top two mantissa bits agree.
`timescale 1ns/10ps
`default_nettype none
`include "fau_defs.svh"
module fau_norm (
	fau_if.norm nif
);
	import fau_pkg::*;
	fau_word_t m;
	fau_exp_t e;
	logic stop;

	// Shifting halts at the smallest exponent so underflow ends the cycle.
	always_comb begin
		m = nif.nm_mant;
		e = nif.nm_exp;
		stop = !nif.nm_float;
		for (int i = 0; i < `FAU_NORM_MAX; i++) begin
			if (!stop && m[47] == m[46] && e > `FAU_EXP_MIN) begin
				m = {m[46:0], 1'b0}; // RQ22
				e = e - 14'sh0001;
			end else begin
				stop = 1'b1;
			end
		end
	end

	assign nif.nm_mant_o = m;
	assign nif.nm_exp_o = e;
	// A mantissa that is still zero, or a prior underflow, gives zero.
	assign nif.nm_zero = nif.nm_float &&
		(m[47:`FAU_MANT_LSB] == 36'h000000000 ||
		nif.nm_exp < `FAU_EXP_MIN); // RQ22
endmodule : fau_norm
`default_nettype wire

// file: fau_pkg.sv
// Types shared by the floating arithmetic unit.
package fau_pkg;
	typedef logic [47:0] fau_word_t;
	typedef logic signed [13:0] fau_exp_t;
	typedef enum logic [2:0] {
		op_add, op_sub, op_mul, op_div, op_mul_accum_add, op_mul_accum_sub
	} fau_op_t;
	typedef enum logic [8:0] {
		s_idle = 9'h001, s_read = 9'h002, s_setup = 9'h004,
		s_rewr = 9'h008, s_align = 9'h010, s_divchk = 9'h020,
		s_arith = 9'h040, s_norm = 9'h080, s_fin = 9'h100
	} fau_state_t;
	typedef struct packed {
		fau_state_t state;
		fau_op_t op;
		logic fl, rnd, dbl, sto, wdone, stored, mdone, shd, eq, al_go;
		logic [5:0] al_cnt, dcnt;
		fau_word_t a, q, d, ds, a_m, b_m, r_m, lo;
		fau_exp_t e_r;
		logic busy, done, ovf, fault, jz, rhalf, wr_req;
		logic [14:0] jaddr, ret;
		fau_word_t wr_data, acc_out, low_out;
	} fau_st_t;
	typedef struct packed {
		logic busy;
		logic [5:0] cnt;
		fau_word_t val;
	} fau_al_t;
endpackage : fau_pkg

// file: fau_top.sv
// Floating point arithmetic datapath with memory rewrite sequencing.
`timescale 1ns/10ps
`default_nettype none
`include "fau_defs.svh"
module fau_top (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic op_start,
	input wire fau_pkg::fau_op_t op_code,
	input wire logic float_prefix,
	input wire logic round_en,
	input wire logic dbl_len,
	input wire logic store_opt,
	input wire fau_pkg::fau_word_t acc_in,
	input wire fau_pkg::fau_word_t low_in,
	input wire logic mem_valid,
	input wire fau_pkg::fau_word_t mem_data,
	input wire logic mem_wr_ack,
	input wire logic [14:0] next_addr,
	input wire logic half_flag,
	output logic busy,
	output logic done,
	output fau_pkg::fau_word_t acc_out,
	output fau_pkg::fau_word_t low_out,
	output logic mem_wr_req,
	output fau_pkg::fau_word_t mem_wr_data,
	output logic ovf_ind,
	output logic exp_fault,
	output logic jump_zero,
	output logic [14:0] jump_addr,
	output logic [14:0] return_address_reg,
	output logic ret_half
);
	import fau_pkg::*;
	fau_st_t st, nx;
	fau_if dp ();

	fau_align u_align (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.aif(dp.align)
	);
	fau_norm u_norm (
		.nif(dp.norm)
	);

	// Mantissa sits at the top of the word, low twelve bits zero in float.
	function automatic fau_word_t mant(input fau_word_t w, input logic f);
		mant = f ? (w & `FAU_MANT_MASK) : w; // RQ1 RQ20
	endfunction : mant

	// Exponent is a signed field widened for carry and borrow headroom.
	function automatic fau_exp_t expo(input fau_word_t w);
		expo = {{2{w[`FAU_EXP_MSB]}}, w[`FAU_EXP_MSB:0]}; // RQ2 RQ3
	endfunction : expo

	// Packs mantissa and exponent back into one word.
	function automatic fau_word_t pack(input fau_word_t m, input fau_exp_t e,
		input logic f);
		pack = f ? {m[47:`FAU_MANT_LSB], e[`FAU_EXP_MSB:0]} : m; // RQ20
	endfunction : pack

	fau_exp_t ea, ed, eq, diff, adiff, en;
	fau_word_t msk;
	logic need;
	logic rbit;
	logic [48:0] rinc, absa, absb;
	logic signed [95:0] prod;
	logic signed [48:0] r;
	logic [46:0] lp;
	logic signed [94:0] num, bs, quot, rem;
	logic is_add, is_sub, is_mul;

	// The shifter and normalizer work from registered state only.
	assign dp.al_load = st.al_go;
	assign dp.al_din = st.shd ? mant(st.d, 1'b1) : st.a_m;
	assign dp.al_cnt = st.al_cnt;
	assign dp.nm_mant = st.r_m;
	assign dp.nm_exp = st.e_r;
	assign dp.nm_float = st.fl;

	// Next-state logic for the whole sequence of one instruction.
	always_comb begin
		nx = st;
		ea = expo(st.a);
		ed = expo(st.d);
		eq = expo(st.q);
		diff = ea - ed;
		adiff = diff[13] ? -diff : diff;
		en = st.e_r;
		msk = st.fl ? `FAU_MANT_MASK : {48{1'b1}};
		need = !st.sto && !st.wdone;
		// Mantissa products line up with the binary point under bit 47.
		prod = $signed(st.b_m) * $signed(mant(st.q, st.fl)); // RQ13
		rbit = st.fl ? prod[58] : prod[46];
		rinc = (st.rnd && rbit) ? (st.fl ? 49'h0000000001000 :
			49'h0000000000001) : 49'h0; // RQ14
		lp = st.dbl ? (st.fl ? {st.q[46:12], 12'h000} : st.q[46:0]) : 47'h0;
		num = $signed({st.a_m, lp});
		bs = $signed({{47{st.b_m[47]}}, st.b_m});
		// A zero divisor never reaches the divider; the guard keeps X out.
		quot = (st.b_m == 48'h0) ? 95'sh0 : num / bs; // RQ16
		rem = (st.b_m == 48'h0) ? 95'sh0 : num % bs;
		absa = st.a_m[47] ? ({1'b0, ~st.a_m} + 49'h1) : {1'b0, st.a_m};
		absb = st.b_m[47] ? ({1'b0, ~st.b_m} + 49'h1) : {1'b0, st.b_m};
		is_add = st.op == op_add || (st.op == op_mul_accum_add && st.mdone);
		is_sub = st.op == op_sub || (st.op == op_mul_accum_sub && st.mdone);
		is_mul = !is_add && !is_sub && st.op != op_div;
		r = 49'sh0;
		nx.done = 1'b0;
		nx.fault = 1'b0;
		nx.jz = 1'b0;
		nx.al_go = 1'b0;
		if (st.wr_req && mem_wr_ack) begin
			nx.wr_req = 1'b0;
		end
		case (st.state)
			s_idle: begin
				if (op_start) begin
					nx.op = op_code;
					nx.fl = float_prefix; // RQ4
					nx.rnd = round_en;
					nx.dbl = dbl_len;
					nx.sto = store_opt;
					nx.wdone = 1'b0;
					nx.stored = 1'b0;
					nx.mdone = 1'b0;
					nx.dcnt = 6'h00;
					nx.a = acc_in;
					nx.q = low_in;
					nx.busy = 1'b1;
					if (float_prefix) begin
						nx.ovf = 1'b0; // RQ23
					end
					nx.state = s_read;
				end
			end
			s_read: begin
				if (mem_valid) begin
					nx.d = mem_data;
					nx.ds = mem_data;
					nx.wr_data = mem_data;
					nx.a_m = mant(st.a, st.fl);
					nx.b_m = mant(mem_data, st.fl);
					case (st.op)
						op_add, op_sub: begin
							nx.state = s_setup;
						end
						op_mul_accum_add, op_mul_accum_sub: begin
							// Multiplicand goes back to memory first.
							nx.wr_req = 1'b1; // RQ19
							nx.wdone = 1'b1;
							nx.e_r = expo(mem_data) + eq; // RQ13
							nx.state = s_rewr;
						end
						op_mul: begin
							nx.wr_req = !st.sto; // RQ18
							nx.wdone = 1'b1;
							nx.e_r = expo(mem_data) + eq; // RQ13
							nx.state = s_arith;
						end
						default: begin
							nx.wr_req = !st.sto; // RQ18
							nx.wdone = 1'b1;
							// The low-half exponent is never consulted.
							nx.e_r = ea - expo(mem_data); // RQ16 RQ17
							nx.state = s_divchk;
						end
					endcase
				end
			end
			s_setup: begin
				nx.a_m = mant(st.a, st.fl);
				nx.b_m = mant(st.d, st.fl);
				nx.e_r = (ea > ed) ? ea : ed; // RQ10
				nx.eq = 1'b0;
				if (!st.fl) begin
					nx.wr_req = need;
					nx.wdone = 1'b1;
					nx.state = s_arith;
				end else if (adiff > `FAU_ALIGN_MAX) begin
					// Too far apart: the smaller one counts as zero at once.
					if (diff[13]) begin
						nx.a_m = `FAU_FZERO; // RQ6
					end else begin
						nx.b_m = `FAU_FZERO; // RQ6
					end
					nx.wr_req = need;
					nx.wdone = 1'b1;
					nx.state = s_arith;
				end else if (diff[13]) begin
					// Memory operand untouched, so its rewrite runs alongside.
					nx.shd = 1'b0;
					nx.al_cnt = 6'(-diff); // RQ5
					nx.al_go = 1'b1;
					nx.wr_req = need; // RQ9
					nx.wdone = 1'b1;
					nx.state = s_align;
				end else begin
					nx.shd = 1'b1;
					nx.eq = (diff == 14'sh0000);
					nx.al_cnt = (diff == 14'sh0000) ? 6'h01 : diff[5:0]; // RQ8
					if (need) begin
						nx.wr_req = 1'b1; // RQ7
						nx.wdone = 1'b1;
						nx.state = s_rewr;
					end else begin
						nx.al_go = 1'b1;
						nx.state = s_align;
					end
				end
			end
			s_rewr: begin
				if (mem_wr_ack) begin
					if (is_mul) begin
						nx.state = s_arith; // RQ19
					end else begin
						nx.al_go = 1'b1; // RQ7
						nx.state = s_align;
					end
				end
			end
			s_align: begin
				if (!st.al_go && !dp.al_busy) begin
					if (!st.shd) begin
						nx.a_m = dp.al_dout & msk; // RQ5
					end else begin
						// Only the mantissa moves; the exponent bits stay put.
						nx.d = {dp.al_dout[47:`FAU_MANT_LSB],
							st.d[`FAU_EXP_MSB:0]}; // RQ11
						nx.b_m = st.eq ? mant(st.ds, 1'b1) :
							(dp.al_dout & msk); // RQ8
					end
					nx.state = s_arith;
				end
			end
			s_divchk: begin
				// In float the dividend shrinks until below the divisor, at most 36 times; fixed flags overflow.
				if (absa >= absb) begin
					if (!st.fl) begin
						nx.ovf = 1'b1;
						nx.stored = 1'b1;
						nx.state = s_fin;
					end else if (st.dcnt == 6'(`FAU_NORM_MAX)) begin
						nx.fault = 1'b1; // RQ24
						nx.jz = 1'b1;
						nx.jaddr = `FAU_JUMP_ADDR;
						nx.ret = next_addr;
						nx.rhalf = half_flag;
						nx.stored = 1'b1;
						nx.state = s_fin;
					end else begin
						nx.a_m = {st.a_m[47], st.a_m[47:1]} & msk;
						nx.e_r = st.e_r + 14'sh0001;
						nx.dcnt = st.dcnt + 6'h01;
					end
				end else begin
					nx.state = s_arith;
				end
			end
			s_arith: begin
				if (is_add) begin
					r = $signed({st.a_m[47], st.a_m}) +
						$signed({st.b_m[47], st.b_m}); // RQ10
				end else if (is_sub) begin
					r = $signed({st.a_m[47], st.a_m}) +
						$signed({~st.b_m[47], ~st.b_m}) + 49'sh1; // RQ12
				end else if (is_mul) begin
					r = $signed({prod[95], prod[94:47] & msk}) +
						$signed(rinc); // RQ14
					nx.lo = st.fl ? {1'b0, prod[58:24], 12'h000} :
						{1'b0, prod[46:0]};
				end else begin
					r = $signed({quot[47], quot[47:0] & msk});
					nx.lo = rem[47:0] & msk;
				end
				// Float corrects a carry past the sign; fixed flags it.
				if (r[48] != r[47]) begin
					if (st.fl) begin
						nx.r_m = r[48:1] & msk; // RQ21
						en = st.e_r + 14'sh0001;
					end else begin
						nx.r_m = r[47:0];
						nx.ovf = 1'b1; // RQ23
					end
				end else begin
					nx.r_m = r[47:0];
				end
				nx.e_r = en;
				if (is_mul && st.op != op_mul) begin
					// Product becomes the addend of the accumulate step.
					nx.d = pack(nx.r_m, en, st.fl);
					nx.ds = pack(nx.r_m, en, st.fl);
					nx.mdone = 1'b1;
					nx.state = s_setup;
				end else begin
					nx.state = s_norm;
				end
			end
			s_norm: begin
				if (st.fl && dp.nm_exp_o > `FAU_EXP_MAX) begin
					nx.fault = 1'b1; // RQ24
					nx.jz = 1'b1;
					nx.jaddr = `FAU_JUMP_ADDR;
					nx.ret = next_addr;
					nx.rhalf = half_flag;
					nx.stored = 1'b1;
				end else begin
					nx.acc_out = dp.nm_zero ? `FAU_FZERO :
						pack(dp.nm_mant_o, dp.nm_exp_o, st.fl); // RQ22
					if (st.op == op_mul && !st.rnd) begin
						nx.low_out = pack(st.lo, dp.nm_exp_o, st.fl); // RQ15
					end else if (st.op == op_div) begin
						nx.low_out = pack(st.lo, dp.nm_exp_o, st.fl);
					end else begin
						nx.low_out = st.q; // RQ14
					end
				end
				nx.state = s_fin;
			end
			s_fin: begin
				// An overlapped rewrite must finish before the next one.
				if (!st.wr_req) begin
					if (st.sto && !st.stored) begin
						nx.wr_req = 1'b1;
						nx.wr_data = st.acc_out;
						nx.stored = 1'b1;
					end else begin
						nx.done = 1'b1;
						nx.busy = 1'b0;
						nx.state = s_idle;
					end
				end
			end
			default: begin
				nx.state = s_idle;
			end
		endcase
	end

	// State register; every output below is a field of it.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st <= '0;
			st.state <= s_idle;
		end else begin
			st <= nx;
		end
	end

	assign busy = st.busy;
	assign done = st.done;
	assign acc_out = st.acc_out;
	assign low_out = st.low_out;
	assign mem_wr_req = st.wr_req;
	assign mem_wr_data = st.wr_data;
	assign ovf_ind = st.ovf;
	assign exp_fault = st.fault;
	assign jump_zero = st.jz;
	assign jump_addr = st.jaddr;
	assign return_address_reg = st.ret;
	assign ret_half = st.rhalf;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	ovf_clear_a: assert property ( // RQ23
		st.state == s_idle && op_start && float_prefix |=> !ovf_ind)
		else $error("overflow indicator not cleared at float start");
	ovf_float_a: assert property ( // RQ23
		$rose(ovf_ind) |-> !$past(st.fl))
		else $error("overflow indicator set by a float operation");
	mad_order_a: assert property ( // RQ19
		st.state == s_arith && is_mul && st.op != op_mul |-> !mem_wr_req)
		else $error("accumulating multiply began before rewrite");
	mul_overlap_a: assert property ( // RQ18
		st.state == s_read && mem_valid && st.op == op_mul && !st.sto
		|=> mem_wr_req && st.state == s_arith)
		else $error("multiply did not overlap the rewrite");
	far_noshift_a: assert property ( // RQ6
		st.state == s_setup && st.fl && adiff > `FAU_ALIGN_MAX
		|=> !st.al_go && st.state == s_arith)
		else $error("far operand was shifted");
	dshift_order_a: assert property ( // RQ7
		st.al_go && st.shd |-> !mem_wr_req &&
		(st.mdone || st.wr_data == st.ds))
		else $error("memory operand shifted before rewrite");
	dexp_keep_a: assert property ( // RQ11
		st.state == s_align && st.fl |=> st.d[11:0] == $past(st.d[11:0]))
		else $error("memory operand exponent altered");
	larger_exp_a: assert property ( // RQ10
		st.state == s_arith && st.fl && (is_add || is_sub)
		|-> st.e_r == ((ea > ed) ? ea : ed))
		else $error("result exponent is not the larger one");
	fault_jump_a: assert property ( // RQ24
		exp_fault |-> jump_zero && jump_addr == `FAU_JUMP_ADDR &&
		st.state == s_fin && st.stored ##1 !exp_fault)
		else $error("exponent fault without jump to zero");
	round_keep_a: assert property ( // RQ14
		st.state == s_norm && st.op == op_mul && st.rnd && st.fl
		&& dp.nm_exp_o <= `FAU_EXP_MAX |=> low_out == $past(st.q))
		else $error("low register not restored after rounding");
endmodule : fau_top
`default_nettype wire

// file: fau_top_tb.sv
// Self-checking testbench of the floating arithmetic datapath.
`timescale 1ns/10ps
`default_nettype none
module fau_top_tb;
	import fau_pkg::*;
	logic ref_clk, sys_rst, op_start, float_prefix, round_en, dbl_len;
	logic store_opt, mem_valid, mem_wr_ack, half_flag, busy, done, rd_go;
	logic mem_wr_req, ovf_ind, exp_fault, jump_zero, ret_half, slow;
	fau_op_t op_code;
	fau_word_t acc_in, low_in, mem_data, mem_wr_data, acc_out, low_out;
	fau_word_t rd_word, wr_first, wr_last;
	logic [14:0] next_addr, jump_addr, return_address_reg;
	int failures, n_tests, n_faults, cyc, wr_count, rw_gap;

	fau_top fau_top_inst (.ref_clk, .sys_rst, .op_start, .op_code,
		.float_prefix, .round_en, .dbl_len, .store_opt, .acc_in, .low_in,
		.mem_valid, .mem_data, .mem_wr_ack, .next_addr, .half_flag, .busy,
		.done, .acc_out, .low_out, .mem_wr_req, .mem_wr_data, .ovf_ind,
		.exp_fault, .jump_zero, .jump_addr, .return_address_reg, .ret_half);
	fau_mem_model fau_mem_model_inst (.ref_clk, .sys_rst, .rd_go, .rd_word,
		.slow, .mem_wr_req, .mem_wr_data, .mem_valid, .mem_data,
		.mem_wr_ack, .wr_count, .wr_first, .wr_last, .rw_gap);

	// Clock of 8 ns.
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// Fault pulses must come as a pair; a hang is cut off here too.
	always @(posedge ref_clk) begin
		cyc++;
		if (exp_fault === 1'b1 || jump_zero === 1'b1) begin
			n_faults++;
			n_tests++;
			if (exp_fault !== jump_zero) begin
				failures++;
				$display("MISMATCH t=%0t fault pulses apart", $time);
			end
		end
		if (cyc > 20000) begin
			failures++;
			$display("MISMATCH t=%0t timeout", $time);
			end_sim();
		end
	end

	task automatic chk(input fau_word_t got, input fau_word_t exp_v,
		input string what);
		n_tests++;
		if (got !== exp_v) begin
			failures++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp_v);
		end
	endtask : chk

	// One instruction: start it, serve the operand, wait for done.
	task automatic run_op(input fau_op_t op, input logic fl, input logic rnd,
		input logic dbl, input logic sto, input fau_word_t a,
		input fau_word_t q, input fau_word_t d);
		int k;
		@(posedge ref_clk);
		op_start <= 1'b1;
		op_code <= op;
		float_prefix <= fl;
		round_en <= rnd;
		dbl_len <= dbl;
		store_opt <= sto;
		acc_in <= a;
		low_in <= q;
		rd_word <= d;
		rd_go <= 1'b1;
		@(posedge ref_clk);
		op_start <= 1'b0;
		rd_go <= 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 500) begin
			@(posedge ref_clk);
			k++;
		end
		chk(48'(k == 500), 48'h0, "done missing");
		@(posedge ref_clk);
	endtask : run_op

	task automatic test_fixed;
		run_op(op_add, 1'b0, 1'b0, 1'b0, 1'b0, 48'h100000000000, 48'h0,
			48'h200000000000);
		chk(acc_out, 48'h300000000000, "fixed sum");
		run_op(op_add, 1'b0, 1'b0, 1'b0, 1'b0, 48'h400000000000, 48'h0,
			48'h400000000000);
		chk({47'h0, ovf_ind}, 48'h1, "fixed overflow");
	endtask : test_fixed

	// Alignment both ways, equal exponents, far apart, negatives, carry out.
	task automatic test_add;
		fau_op_t to[7] = '{op_add, op_add, op_sub, op_add, op_add, op_add,
			op_sub};
		fau_word_t ta[7] = '{48'h400000000003, 48'h400000000002,
			48'h600000000003, 48'h400000000028, 48'hC00000000FFF,
			48'h500000000003, 48'h400000000005};
		fau_word_t td[7] = '{48'h400000000002, 48'h400000000003,
			48'h400000000003, 48'h400000000000, 48'h400000000FFE,
			48'h600000000003, 48'h400000000005};
		fau_word_t te[7] = '{48'h600000000003, 48'h600000000003,
			48'h400000000002, 48'h400000000028, 48'h800000000FFD,
			48'h580000000004, 48'h000000000000};
		for (int i = 0; i < 7; i++) begin
			slow <= i[0];
			run_op(to[i], 1'b1, 1'b0, 1'b0, 1'b0, ta[i], 48'h0, td[i]);
			chk(acc_out, te[i], "add result");
			chk(wr_first, td[i], "rewrite data");
			chk(48'(wr_count), 48'h1, "write count");
			chk({47'h0, ovf_ind}, 48'h0, "float ovf");
		end
		run_op(op_add, 1'b1, 1'b0, 1'b0, 1'b1, ta[0], 48'h0, td[0]);
		chk(48'(wr_count), 48'h1, "store count");
		chk(wr_last, te[0], "store data");
	endtask : test_add

	// Q equals A so either multiplier pairing gives the same product.
	task automatic test_mul_div;
		run_op(op_mul, 1'b1, 1'b0, 1'b0, 1'b0, 48'h700000000003,
			48'h700000000003, 48'h600000000002);
		chk(acc_out, 48'h540000000005, "product");
		chk({36'h0, low_out[11:0]}, 48'h5, "low exponent");
		chk(48'(rw_gap), 48'h1, "mul overlap");
		run_op(op_mul, 1'b1, 1'b1, 1'b0, 1'b0, 48'h700000000003,
			48'h700000000003, 48'h600000000002);
		chk(acc_out, 48'h540000000005, "rounded product");
		chk(low_out, 48'h700000000003, "low restored");
		// Product falls exactly on the low-half top bit, so rounding carries.
		run_op(op_mul, 1'b1, 1'b1, 1'b0, 1'b0, 48'h400000000000,
			48'h400000000000, 48'h000000001000);
		chk(acc_out, 48'h400000000FDE, "round carry");
		// Minus one squared overflows the mantissa and must be corrected.
		run_op(op_mul, 1'b1, 1'b0, 1'b0, 1'b0, 48'h800000000000,
			48'h800000000000, 48'h800000000000);
		chk(acc_out, 48'h400000000001, "product carry");
		chk({47'h0, ovf_ind}, 48'h0, "product carry ovf");
		run_op(op_div, 1'b1, 1'b0, 1'b0, 1'b0, 48'h3C0000000005, 48'h0,
			48'h400000000001);
		chk(acc_out, 48'h780000000004, "quotient");
		chk(48'(rw_gap), 48'h1, "div overlap");
		run_op(op_div, 1'b1, 1'b0, 1'b1, 1'b0, 48'h3C0000000005,
			48'h000000000ABC, 48'h400000000001);
		chk(acc_out, 48'h780000000004, "double quotient");
		run_op(op_mul_accum_add, 1'b1, 1'b0, 1'b0, 1'b0, 48'h400000000001,
			48'h400000000001, 48'h400000000001);
		chk(acc_out, 48'h400000000002, "accum add");
		chk(wr_first, 48'h400000000001, "accum rewrite");
		run_op(op_mul_accum_sub, 1'b1, 1'b0, 1'b0, 1'b0, 48'h400000000001,
			48'h400000000001, 48'h400000000001);
		chk(acc_out, 48'h000000000000, "accum sub");
	endtask : test_mul_div

	// Divide by zero, then exponent overflow left after normalizing.
	task automatic test_fault;
		fau_word_t keep;
		keep = acc_out;
		next_addr <= 15'h1234;
		half_flag <= 1'b1;
		run_op(op_div, 1'b1, 1'b0, 1'b0, 1'b0, 48'h400000000001, 48'h0,
			48'h000000000001);
		chk(48'(n_faults), 48'h1, "zero divide fault");
		chk({33'h0, return_address_reg}, 48'h1234, "return addr");
		chk({47'h0, ret_half}, 48'h1, "return half");
		chk({33'h0, jump_addr}, 48'h0, "jump addr");
		chk(acc_out, keep, "result kept");
		next_addr <= 15'h0055;
		half_flag <= 1'b0;
		run_op(op_mul, 1'b1, 1'b0, 1'b0, 1'b0, 48'h4000000007FF,
			48'h4000000007FF, 48'h600000000002);
		chk(48'(n_faults), 48'h2, "exponent fault");
		chk({33'h0, return_address_reg}, 48'h0055, "return addr");
		chk({47'h0, ret_half}, 48'h0, "return half");
	endtask : test_fault

	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim

	// Reset for five cycles, then the scenarios in turn.
	initial begin
		sys_rst = 1'b1;
		op_start = 1'b0;
		op_code = op_add;
		{float_prefix, round_en, dbl_len, store_opt} = 4'h0;
		{half_flag, rd_go, slow} = 3'h0;
		acc_in = 48'h0;
		low_in = 48'h0;
		rd_word = 48'h0;
		next_addr = 15'h0;
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		chk({43'h0, busy, done, mem_wr_req, ovf_ind, exp_fault}, 48'h0,
			"reset state");
		test_fixed();
		test_add();
		test_mul_div();
		test_fault();
		end_sim();
	end
endmodule : fau_top_tb
`default_nettype wire
